/* hdl/tgc_pkg.sv */
// tgc_pkg: register map, field positions, reset values and counts of the gated counter
package tgc_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_COUNTER_CONTROL = 8'h00;
    localparam logic [7:0] OFF_GATE_CONTROL = 8'h04;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h08;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h0c;
    localparam logic [7:0] OFF_PERIPH_FLAG = 8'h10;
    localparam logic [7:0] OFF_PERIPH_ENABLE = 8'h14;
    localparam logic [7:0] OFF_INT_CONTROL = 8'h18;

    // ------------------------------------------------------------
    // counter_control fields
    // ------------------------------------------------------------
    localparam int CC_CS_LSB = 6;
    localparam int CC_PS_LSB = 4;
    localparam int CC_SYNC_BIT = 2;
    localparam int CC_ON_BIT = 0;
    localparam logic [7:0] CC_RESET = 8'h00;
    localparam logic [7:0] CC_WMASK = 8'hf5;

    // ------------------------------------------------------------
    // gate_control_reg fields
    // ------------------------------------------------------------
    localparam int GC_EN_BIT = 7;
    localparam int GC_POL_BIT = 6;
    localparam int GC_TM_BIT = 5;
    localparam int GC_SPM_BIT = 4;
    localparam int GC_GO_BIT = 3;
    localparam int GC_VAL_BIT = 2;
    localparam int GC_GSS_LSB = 0;
    localparam logic [7:0] GC_RESET = 8'h00;

    // ------------------------------------------------------------
    // flag, enable and interrupt control fields
    // ------------------------------------------------------------
    localparam int PF_OVF_BIT = 0;
    localparam int PF_GATE_BIT = 7;
    localparam int IC_GIE_BIT = 7;
    localparam int IC_PERIPHERAL_IRQ_ENABLE_BIT = 6;

    // ------------------------------------------------------------
    // encodings and counts
    // ------------------------------------------------------------
    localparam logic [1:0] CS_LFOSC = 2'h3;
    localparam logic [1:0] CS_EXT = 2'h2;
    localparam logic [1:0] CS_SYS = 2'h1;
    localparam logic [1:0] CS_INSTR = 2'h0;
    localparam logic [1:0] GSS_PIN = 2'h0;
    localparam logic [1:0] GSS_T0OVF = 2'h1;
    localparam logic [1:0] GSS_CMP = 2'h2;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam logic [7:0] T0_TOP = 8'hff;
    localparam logic [15:0] COUNT_TOP = 16'hffff;

endpackage

/* hdl/tgc_timer1_gate.sv */
// tgc_timer1_gate: gated 16-bit counter with clock select, prescaler and wishbone registers
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/100ps

module tgc_timer1_gate (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // counting and gate sources
    input wire logic gate_input_pin,
    input wire logic [7:0] eight_bit_timer_count,
    input wire logic comparator_synced_output,
    input wire logic external_clock_pin,
    input wire logic low_freq_internal_osc,
    // power state
    input wire logic sleep_mode,
    // requests to the core
    output logic irq_req,
    output logic wake_req,
    output logic isr_vector_req
);

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0] cc_q;
    logic gen_q, gpol_q, gtm_q, gspm_q, ggo_q;
    logic [1:0] gss_q;
    logic [15:0] count_q;
    logic ovf_flag_q, gate_flag_q, ovf_ie_q, gate_ie_q, gie_q, peripheral_irq_enable_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] t0_prev_q;
    logic t0_wrap_q;
    logic ext_s1_q, ext_s2_q, ext_prev_q, lf_prev_q;
    logic [1:0] idiv_q;
    logic [2:0] psc_q;
    logic tff_q, gsrc_prev_q, capture_q, gate_level_q, gate_level_prev_q;
    logic irq_q, wake_q, vec_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req, wr, wr_cc, wr_gc, wr_lo, wr_hi, wr_pf, wr_pe, wr_ic;
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wr_cc = wr && (wb_adr_i == tgc_pkg::OFF_COUNTER_CONTROL);
    assign wr_gc = wr && (wb_adr_i == tgc_pkg::OFF_GATE_CONTROL);
    assign wr_lo = wr && (wb_adr_i == tgc_pkg::OFF_COUNT_LOW);
    assign wr_hi = wr && (wb_adr_i == tgc_pkg::OFF_COUNT_HIGH);
    assign wr_pf = wr && (wb_adr_i == tgc_pkg::OFF_PERIPH_FLAG);
    assign wr_pe = wr && (wb_adr_i == tgc_pkg::OFF_PERIPH_ENABLE);
    assign wr_ic = wr && (wb_adr_i == tgc_pkg::OFF_INT_CONTROL);

    logic on, sync_bypass;
    logic [1:0] cs, ps;
    assign cs = cc_q[tgc_pkg::CC_CS_LSB +: 2];
    assign ps = cc_q[tgc_pkg::CC_PS_LSB +: 2];
    assign sync_bypass = cc_q[tgc_pkg::CC_SYNC_BIT];
    assign on = cc_q[tgc_pkg::CC_ON_BIT];

    // ------------------------------------------------------------
    // clock source and prescaler
    // ------------------------------------------------------------
    logic ext_edge, lf_edge, src_tick, psc_last, psc_tick, awake_ok, inc;
    // synchronised edge looks at the second stage only
    assign ext_edge = sync_bypass ? (external_clock_pin && !ext_prev_q)
                                  : (ext_s2_q && !ext_prev_q);
    assign lf_edge = low_freq_internal_osc && !lf_prev_q;

    always_comb begin
        unique case (cs)
            tgc_pkg::CS_LFOSC: src_tick = lf_edge;
            tgc_pkg::CS_EXT: src_tick = ext_edge;
            tgc_pkg::CS_SYS: src_tick = 1'b1;
            tgc_pkg::CS_INSTR: src_tick = (idiv_q == tgc_pkg::INSTR_DIV_LAST);
        endcase
    end

    always_comb begin
        unique case (ps)
            2'h3: psc_last = (psc_q == 3'h7);
            2'h2: psc_last = (psc_q[1:0] == 2'h3);
            2'h1: psc_last = psc_q[0];
            2'h0: psc_last = 1'b1;
        endcase
    end

    assign psc_tick = src_tick && psc_last;
    // in sleep only the unsynchronised external counter keeps running
    assign awake_ok = !sleep_mode || (sync_bypass && cs == tgc_pkg::CS_EXT);
    assign inc = on && psc_tick && awake_ok && (!gen_q || gate_level_q);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
            lf_prev_q <= 1'b0;
        end else begin
            ext_s1_q <= external_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= sync_bypass ? external_clock_pin : ext_s2_q;
            lf_prev_q <= low_freq_internal_osc;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            idiv_q <= 2'h0;
        end else begin
            idiv_q <= idiv_q + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            psc_q <= 3'h0;
        end else if (wr_lo || wr_hi || !on) begin
            psc_q <= 3'h0;
        end else if (src_tick && awake_ok) begin
            psc_q <= psc_last ? 3'h0 : psc_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // gate path
    // ------------------------------------------------------------
    logic gate_src, gate_pol, gate_toggled, gate_rise, gate_fall, gate_level_d;

    always_comb begin
        unique case (gss_q)
            tgc_pkg::GSS_PIN: gate_src = gate_input_pin;
            tgc_pkg::GSS_T0OVF: gate_src = t0_wrap_q;
            tgc_pkg::GSS_CMP: gate_src = comparator_synced_output;
            default: gate_src = 1'b0;
        endcase
    end

    // active level is high after polarity
    assign gate_pol = gpol_q ? gate_src : !gate_src;
    assign gate_rise = gate_pol && !gsrc_prev_q;
    assign gate_toggled = gtm_q ? tff_q : gate_pol;
    assign gate_fall = !gate_toggled && gate_level_prev_q;
    assign gate_level_d = gspm_q ? (gate_toggled && capture_q) : gate_toggled;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            t0_prev_q <= 8'h00;
            t0_wrap_q <= 1'b0;
        end else begin
            t0_prev_q <= eight_bit_timer_count;
            t0_wrap_q <= (t0_prev_q == tgc_pkg::T0_TOP) && (eight_bit_timer_count == 8'h00);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gsrc_prev_q <= 1'b0;
            tff_q <= 1'b0;
        end else begin
            gsrc_prev_q <= gate_pol;
            if (!gtm_q || !on) begin
                tff_q <= 1'b0;
            end else if (gate_rise) begin
                tff_q <= !tff_q;
            end
        end
    end

    // capture window opens on a rising gate edge while armed
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            capture_q <= 1'b0;
            gate_level_prev_q <= 1'b0;
        end else begin
            gate_level_prev_q <= gate_toggled;
            if (!gspm_q || !ggo_q) begin
                capture_q <= 1'b0;
            end else if (gate_toggled && !gate_level_prev_q) begin
                capture_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gate_level_q <= 1'b0;
        end else begin
            gate_level_q <= gate_level_d;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cc_q <= tgc_pkg::CC_RESET;
        end else if (wr_cc) begin
            cc_q <= wb_dat_i[7:0] & tgc_pkg::CC_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gen_q <= tgc_pkg::GC_RESET[tgc_pkg::GC_EN_BIT];
            gpol_q <= tgc_pkg::GC_RESET[tgc_pkg::GC_POL_BIT];
            gtm_q <= tgc_pkg::GC_RESET[tgc_pkg::GC_TM_BIT];
            gspm_q <= tgc_pkg::GC_RESET[tgc_pkg::GC_SPM_BIT];
            gss_q <= tgc_pkg::GC_RESET[tgc_pkg::GC_GSS_LSB +: 2];
        end else if (wr_gc) begin
            gen_q <= wb_dat_i[tgc_pkg::GC_EN_BIT];
            gpol_q <= wb_dat_i[tgc_pkg::GC_POL_BIT];
            gtm_q <= wb_dat_i[tgc_pkg::GC_TM_BIT];
            gspm_q <= wb_dat_i[tgc_pkg::GC_SPM_BIT];
            gss_q <= wb_dat_i[tgc_pkg::GC_GSS_LSB +: 2];
        end
    end

    // hardware clear on trailing edge beats a software set in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ggo_q <= tgc_pkg::GC_RESET[tgc_pkg::GC_GO_BIT];
        end else if (gspm_q && capture_q && gate_fall) begin
            ggo_q <= 1'b0;
        end else if (wr_gc) begin
            ggo_q <= wb_dat_i[tgc_pkg::GC_GO_BIT];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ovf_ie_q <= 1'b0;
            gate_ie_q <= 1'b0;
            gie_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
        end else begin
            if (wr_pe) begin
                ovf_ie_q <= wb_dat_i[tgc_pkg::PF_OVF_BIT];
                gate_ie_q <= wb_dat_i[tgc_pkg::PF_GATE_BIT];
            end
            if (wr_ic) begin
                gie_q <= wb_dat_i[tgc_pkg::IC_GIE_BIT];
                peripheral_irq_enable_q <= wb_dat_i[tgc_pkg::IC_PERIPHERAL_IRQ_ENABLE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // counter and flags
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 16'h0000;
        end else if (wr_lo) begin
            count_q <= {count_q[15:8], wb_dat_i[7:0]};
        end else if (wr_hi) begin
            count_q <= {wb_dat_i[7:0], count_q[7:0]};
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ovf_flag_q <= 1'b0;
            gate_flag_q <= 1'b0;
        end else begin
            if (inc && !wr_lo && !wr_hi && count_q == tgc_pkg::COUNT_TOP) begin
                ovf_flag_q <= 1'b1;
            end else if (wr_pf) begin
                ovf_flag_q <= wb_dat_i[tgc_pkg::PF_OVF_BIT];
            end
            if (!gate_level_d && gate_level_q) begin
                gate_flag_q <= 1'b1;
            end else if (wr_pf) begin
                gate_flag_q <= wb_dat_i[tgc_pkg::PF_GATE_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt and wake requests
    // ------------------------------------------------------------
    logic ovf_take, gate_take;
    assign ovf_take = ovf_flag_q && ovf_ie_q && on && peripheral_irq_enable_q;
    assign gate_take = gate_flag_q && gate_ie_q && peripheral_irq_enable_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
            vec_q <= 1'b0;
        end else begin
            irq_q <= gie_q && (ovf_take || gate_take);
            wake_q <= sleep_mode && ovf_take;
            vec_q <= sleep_mode && ovf_take && gie_q;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            if (req) begin
                unique case (wb_adr_i)
                    tgc_pkg::OFF_COUNTER_CONTROL: rdata_q <= {24'h000000, cc_q};
                    tgc_pkg::OFF_GATE_CONTROL: rdata_q <= {24'h000000, gen_q, gpol_q, gtm_q,
                        gspm_q, ggo_q, gate_level_q, gss_q};
                    tgc_pkg::OFF_COUNT_LOW: rdata_q <= {24'h000000, count_q[7:0]};
                    tgc_pkg::OFF_COUNT_HIGH: rdata_q <= {24'h000000, count_q[15:8]};
                    tgc_pkg::OFF_PERIPH_FLAG: rdata_q <= {24'h000000, gate_flag_q, 6'h00,
                        ovf_flag_q};
                    tgc_pkg::OFF_PERIPH_ENABLE: rdata_q <= {24'h000000, gate_ie_q, 6'h00,
                        ovf_ie_q};
                    tgc_pkg::OFF_INT_CONTROL: rdata_q <= {24'h000000, gie_q, peripheral_irq_enable_q, 6'h00};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign irq_req = irq_q;
    assign wake_req = wake_q;
    assign isr_vector_req = vec_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    t0_wrap_pulse_a: assert property (
        ($past(resetn) && $past(eight_bit_timer_count) == 8'hff
            && eight_bit_timer_count == 8'h00) |=> t0_wrap_q)
        else $error("eight-bit wrap pulse missing");
    toggle_hold_a: assert property (!gtm_q |=> !tff_q)
        else $error("toggle flop not held clear");
    arm_clear_a: assert property (
        (gspm_q && capture_q && gate_fall) |=> !ggo_q ##1 !capture_q)
        else $error("arm bit not cleared on trailing edge");
    gate_flag_set_a: assert property ($fell(gate_level_q) |-> gate_flag_q)
        else $error("gate event flag not set on falling level");
    count_wrap_a: assert property (
        (inc && !wr_lo && !wr_hi && count_q == 16'hffff) |=> count_q == 16'h0000 && ovf_flag_q)
        else $error("counter wrap did not set overflow flag");
    irq_qual_a: assert property (
        $rose(irq_q) |-> $past(gie_q && peripheral_irq_enable_q && (gate_take || (ovf_ie_q && on))))
        else $error("interrupt raised without its enables");
    off_no_count_a: assert property (!on |=> $stable(count_q) || $past(wr_lo || wr_hi))
        else $error("counter moved while off");
    presc_eight_a: assert property (
        (ps == 2'h3 && inc) |-> psc_q == 3'h7)
        else $error("divide by eight tick early");
    sleep_stop_a: assert property (
        (sleep_mode && !(sync_bypass && cs == 2'h2)) |-> !inc)
        else $error("counting in sleep outside asynchronous mode");
    wake_vec_a: assert property (vec_q |-> wake_q)
        else $error("vector request without wake");

endmodule

/* test/tgc_gate_partner.sv */
// tgc_gate_partner: behavioural model of the gate, clock and eight-bit timer sources
`timescale 1ns/100ps
module tgc_gate_partner (
    // clock
    input wire logic mclk,
    // commands from the bench
    input wire logic gate_lvl,
    input wire logic cmp_lvl,
    input wire logic t0_run,
    input wire logic ext_run,
    // sources toward the counter
    output logic gate_input_pin,
    output logic [7:0] eight_bit_timer_count,
    output logic comparator_synced_output,
    output logic external_clock_pin,
    output logic low_freq_internal_osc
);
    logic [2:0] ext_div_q = 3'h0;
    logic [3:0] osc_div_q = 4'h0;
    logic [7:0] t0_q = 8'h00;
    // external clock stands still low outside a measurement window
    always @(posedge mclk) begin
        ext_div_q <= ext_run ? ext_div_q + 3'h1 : 3'h0;
        osc_div_q <= osc_div_q + 4'h1;
        t0_q <= t0_q + {7'h0, t0_run};
    end
    assign eight_bit_timer_count = t0_q;
    assign external_clock_pin = ext_div_q[2];
    assign low_freq_internal_osc = osc_div_q[3];
    assign gate_input_pin = gate_lvl;
    assign comparator_synced_output = cmp_lvl;
endmodule

/* test/tgc_timer1_gate_tb_top.sv */
// tgc_timer1_gate_tb_top: self-checking bench for the gated 16-bit counter
`timescale 1ns/100ps
module tgc_timer1_gate_tb_top;
    typedef struct packed {
        logic [7:0] gc;
        logic pin;
        logic [7:0] cc;
        logic [15:0] cnt;
    } tgc_row_t;
    logic mclk = 1'b0, resetn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic sleep_mode = 1'b0, gate_lvl = 1'b0, cmp_lvl = 1'b0, t0_run = 1'b0, ext_run = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_q, v;
    logic wb_ack, gate_pin, cmp_out, ext_clk, lf_osc, irq_req, wake_req, isr_vector_req;
    logic [7:0] t0_cnt;
    int n_mismatch = 0;
    int comparisons = 0;
    // gate control, gate pin, counter control, count after a 64-cycle window
    tgc_row_t rows [12] = '{
        '{8'h00, 1'b0, 8'h41, 16'h42}, '{8'h00, 1'b0, 8'h51, 16'h21},
        '{8'h00, 1'b0, 8'h61, 16'h10}, '{8'h00, 1'b0, 8'h71, 16'h08},
        '{8'h00, 1'b0, 8'h01, 16'h10}, '{8'h00, 1'b0, 8'h81, 16'h08},
        '{8'h00, 1'b0, 8'h85, 16'h08}, '{8'h00, 1'b0, 8'hc1, 16'h04},
        '{8'hc0, 1'b0, 8'h41, 16'h00}, '{8'hc0, 1'b1, 8'h41, 16'h42},
        '{8'h80, 1'b0, 8'h41, 16'h42}, '{8'h80, 1'b1, 8'h41, 16'h00}
    };

    always #2 mclk = ~mclk;

    tgc_timer1_gate dut_u (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
        .wb_ack_o(wb_ack), .gate_input_pin(gate_pin), .eight_bit_timer_count(t0_cnt),
        .comparator_synced_output(cmp_out), .external_clock_pin(ext_clk),
        .low_freq_internal_osc(lf_osc), .sleep_mode(sleep_mode), .irq_req(irq_req),
        .wake_req(wake_req), .isr_vector_req(isr_vector_req));
    tgc_gate_partner far_u (.mclk(mclk), .gate_lvl(gate_lvl), .cmp_lvl(cmp_lvl), .t0_run(t0_run),
        .ext_run(ext_run), .gate_input_pin(gate_pin), .eight_bit_timer_count(t0_cnt),
        .comparator_synced_output(cmp_out), .external_clock_pin(ext_clk),
        .low_freq_internal_osc(lf_osc));

    // ------------------------------------------------------------
    // bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // counts taken over a window may be off by a cycle or two of latency
    task automatic near(input logic [31:0] seen, input logic [31:0] exp);
        chk((seen + 2 >= exp && seen <= exp + 2) ? exp : seen, exp);
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= {24'h0, d};
        do begin
            @(posedge mclk);
        end while (wb_ack !== 1'b1);
        v = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 8'h00);
    endtask
    task automatic zero_count();
        wr(tgc_pkg::OFF_COUNT_LOW, 8'h00);
        wr(tgc_pkg::OFF_COUNT_HIGH, 8'h00);
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        wb_sel <= 4'he;
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h41);
        wb_sel <= 4'hf;
        wr(8'h1c, 8'hff);
        for (int a = 0; a < 32; a += 4) begin
            rd(8'(a));
            chk(v & (a == 4 ? 32'hfb : 32'hff), 32'h0);
        end
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'hff);
        rd(tgc_pkg::OFF_COUNTER_CONTROL);
        chk(v, 32'hf5);
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            zero_count();
            wr(tgc_pkg::OFF_PERIPH_FLAG, 8'h00);
            wr(tgc_pkg::OFF_PERIPH_ENABLE, 8'h01);
            wr(tgc_pkg::OFF_INT_CONTROL, i == 0 ? 8'hc0 : 8'h40);
            wr(tgc_pkg::OFF_COUNT_LOW, 8'hf0);
            wr(tgc_pkg::OFF_COUNT_HIGH, 8'hff);
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h41);
            repeat (40) @(posedge mclk);
            chk(irq_req, i == 0);
            rd(tgc_pkg::OFF_PERIPH_FLAG);
            chk(v[0], 1'b1);
            wr(tgc_pkg::OFF_PERIPH_FLAG, 8'h00);
            repeat (2) @(posedge mclk);
            chk(irq_req, 1'b0);
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
            rd(tgc_pkg::OFF_COUNT_HIGH);
            chk(v, 32'h0);
            $display("test overflow %0d done", i);
        end
        foreach (rows[r]) begin
            gate_lvl <= rows[r].pin;
            wr(tgc_pkg::OFF_GATE_CONTROL, rows[r].gc);
            zero_count();
            ext_run <= 1'b1;
            wr(tgc_pkg::OFF_COUNTER_CONTROL, rows[r].cc);
            repeat (64) @(posedge mclk);
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
            ext_run <= 1'b0;
            rd(tgc_pkg::OFF_COUNT_LOW);
            near(v, rows[r].cnt);
            $display("test row %0d done", r);
        end
        wr(tgc_pkg::OFF_PERIPH_ENABLE, 8'h80);
        wr(tgc_pkg::OFF_INT_CONTROL, 8'hc0);
        for (int s = 0; s < 4; s++) begin
            wr(tgc_pkg::OFF_GATE_CONTROL, 8'h40 | 8'(s));
            wr(tgc_pkg::OFF_PERIPH_FLAG, 8'h00);
            {gate_lvl, cmp_lvl, t0_run} <= 3'b111;
            repeat (300) @(posedge mclk);
            rd(tgc_pkg::OFF_GATE_CONTROL);
            chk(v[2], s == 0 || s == 2);
            {gate_lvl, cmp_lvl, t0_run} <= 3'b000;
            repeat (4) @(posedge mclk);
            rd(tgc_pkg::OFF_PERIPH_FLAG);
            chk(v[7], s != 3);
            chk(irq_req, s != 3);
            $display("test gate source %0d done", s);
        end
        for (int k = 0; k < 2; k++) begin
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
            zero_count();
            wr(tgc_pkg::OFF_GATE_CONTROL, k ? 8'hf0 : 8'hd0);
            wr(tgc_pkg::OFF_GATE_CONTROL, k ? 8'hf8 : 8'hd8);
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h41);
            repeat (3) begin
                gate_lvl <= 1'b1;
                repeat (20) @(posedge mclk);
                gate_lvl <= 1'b0;
                repeat (20) @(posedge mclk);
            end
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
            rd(tgc_pkg::OFF_GATE_CONTROL);
            chk(v[3], 1'b0);
            rd(tgc_pkg::OFF_COUNT_LOW);
            near(v, k ? 32'h28 : 32'h14);
            $display("test single pulse %0d done", k);
        end
        for (int g = 0; g < 2; g++) begin
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
            wr(tgc_pkg::OFF_GATE_CONTROL, 8'h00);
            wr(tgc_pkg::OFF_COUNT_LOW, 8'hf8);
            wr(tgc_pkg::OFF_COUNT_HIGH, 8'hff);
            wr(tgc_pkg::OFF_PERIPH_FLAG, 8'h00);
            wr(tgc_pkg::OFF_PERIPH_ENABLE, 8'h01);
            wr(tgc_pkg::OFF_INT_CONTROL, g ? 8'hc0 : 8'h40);
            wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h85);
            {sleep_mode, ext_run} <= 2'b11;
            n = 0;
            while (wake_req !== 1'b1 && n < 400) begin
                @(posedge mclk);
                n++;
            end
            chk(wake_req, 1'b1);
            chk(isr_vector_req, g);
            {sleep_mode, ext_run} <= 2'b00;
        end
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
        wr(tgc_pkg::OFF_PERIPH_FLAG, 8'h00);
        zero_count();
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h81);
        {sleep_mode, ext_run} <= 2'b11;
        repeat (100) @(posedge mclk);
        {sleep_mode, ext_run} <= 2'b00;
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h00);
        rd(tgc_pkg::OFF_COUNT_LOW);
        chk(v, 32'h0);
        $display("test sleep done");
        wr(tgc_pkg::OFF_COUNTER_CONTROL, 8'h41);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rd(tgc_pkg::OFF_COUNTER_CONTROL);
        chk(v, 32'h0);
        repeat (8) @(posedge mclk);
        rd(tgc_pkg::OFF_COUNT_LOW);
        chk(v, 32'h0);
        $display("test reset in run done");
        complete_run();
    end
endmodule
